// ---- hdl/elpc_pkg.sv ----
// Package of the exception and low-power controller: offsets, fields, codes, counts and carriers.
// Assumes one 25 MHz bus clock that also stands in for the crystal reference clock.
package elpc_pkg;

    // ==========================================================
    // Register map (byte addresses on AHB-Lite)
    localparam logic [7:0] ELPC_OFS_FLAGS_LOW = 8'h00;
    localparam logic [7:0] ELPC_OFS_FLAGS_MID = 8'h04;
    localparam logic [7:0] ELPC_OFS_FLAGS_HIGH = 8'h08;
    localparam logic [7:0] ELPC_OFS_BRK_CTRL = 8'h0C;
    localparam logic [7:0] ELPC_OFS_BRK_STAT = 8'h10;
    localparam logic [7:0] ELPC_OFS_OPTION = 8'h14;

    // ==========================================================
    // Field positions and reset values
    localparam int ELPC_BREAK_FLAG_CLEAR_ENABLE_BIT = 0;
    localparam int ELPC_WAKE_BIT = 0;
    localparam int ELPC_SHORT_RECOVERY_SELECT_BIT = 0;
    localparam logic ELPC_BREAK_FLAG_CLEAR_ENABLE_RST = 1'b0;
    localparam logic ELPC_SHORT_RECOVERY_SELECT_RST = 1'b0;
    localparam logic [31:0] ELPC_RDATA_RST = 32'h0000_0000;

    // ==========================================================
    // Interrupt sources and vector codes
    localparam int ELPC_NUM_IRQ = 20;
    localparam logic [4:0] ELPC_VEC_RESET = 5'h00;
    localparam logic [4:0] ELPC_VEC_SWI = 5'h01;
    localparam logic [4:0] ELPC_VEC_IRQ_BASE = 5'h02;

    // ==========================================================
    // Stop recovery, in crystal clock cycles
    localparam int ELPC_RECOV_LONG_CYC = 4096;
    localparam int ELPC_RECOV_SHORT_CYC = 32;
    localparam int ELPC_CNT_W = 13;
    localparam logic [ELPC_CNT_W-1:0] ELPC_RECOV_LONG_CNT = ELPC_CNT_W'(ELPC_RECOV_LONG_CYC - 1);
    localparam logic [ELPC_CNT_W-1:0] ELPC_RECOV_SHORT_CNT = ELPC_CNT_W'(ELPC_RECOV_SHORT_CYC - 1);

    // ==========================================================
    // AHB-Lite codes
    localparam logic [1:0] ELPC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] ELPC_HSIZE_WORD = 3'h2;

    // ==========================================================
    // Sequencer states and carriers
    typedef enum logic [2:0] {
        ELPC_RUN,
        ELPC_ENTRY,
        ELPC_SERVICE,
        ELPC_WAIT,
        ELPC_STOP,
        ELPC_RECOVER
    } elpc_state_t;

    typedef struct packed {
        logic int_start;
        logic stack_push;
        logic set_imask;
        logic clear_imask;
        logic pc_minus_one;
        logic stack_high_index;
        logic discard_prefetch;
        logic [4:0] vector_sel;
    } elpc_cpu_ctl_t;

    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic main_clk_en;
        logic xtal_clk_en;
    } elpc_clk_ctl_t;

endpackage : elpc_pkg

// ---- hdl/elpc_recovery_counter.sv ----
// Stabilisation counter that times stop-mode recovery.
// Assumes the crystal reference clock runs at the bus clock rate.
`timescale 1ns/1ps
`default_nettype none

module elpc_recovery_counter
    import elpc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hold_clear,
    input wire logic short_sel,
    output logic done
);

    // ==========================================================
    // Counter state
    typedef struct packed {
        logic [ELPC_CNT_W-1:0] count;
        logic done;
    } elpc_cnt_state_t;

    elpc_cnt_state_t cur;
    elpc_cnt_state_t next_cur;
    logic [ELPC_CNT_W-1:0] last;

    always_comb begin
        next_cur = cur;
        last = short_sel ? ELPC_RECOV_SHORT_CNT : ELPC_RECOV_LONG_CNT;
        if (hold_clear) begin
            next_cur.count = '0;
            next_cur.done = 1'b0;
        end else if (cur.count == last) begin
            next_cur.done = 1'b1;
        end else begin
            next_cur.count = cur.count + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign done = cur.done;

endmodule : elpc_recovery_counter

`default_nettype wire

// ---- hdl/elpc_top.sv ----
// Exception and low-power controller: interrupt latching and arbitration, trap and break
// redirection, break-mode flag protection, wait and stop sequencing, AHB-Lite registers.
// Assumes the core gives one-cycle pulses at instruction boundaries and for trap, wait and stop.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module elpc_top
    import elpc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [ELPC_NUM_IRQ-1:0] irq_req,
    input wire logic [ELPC_NUM_IRQ-1:0] irq_enable,
    input wire logic cpu_imask,
    input wire logic instr_done,
    input wire logic rti_done,
    input wire logic trap_exec,
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic vector_ack,
    input wire logic reset_req,
    input wire logic break_req,
    input wire logic break_exit,
    input wire logic emu_mode,
    output logic core_reset,
    output logic int_start,
    output logic stack_push,
    output logic set_imask,
    output logic clear_imask,
    output logic pc_minus_one,
    output logic stack_high_index,
    output logic discard_prefetch,
    output logic [4:0] vector_sel,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic main_clk_en,
    output logic xtal_clk_en,
    output logic break_state,
    output logic flag_clear_allow,
    output logic stab_hold_clear
);

    // ==========================================================
    // Arbitration helper
    function automatic logic [5:0] pick_source(input logic [ELPC_NUM_IRQ-1:0] live);
        logic [5:0] res;
        res = '0;
        for (int i = ELPC_NUM_IRQ - 1; i >= 0; i--) begin
            if (live[i]) begin
                res = {1'b1, 5'(i)};
            end
        end
        return res;
    endfunction : pick_source

    // ==========================================================
    // Module state
    typedef struct packed {
        elpc_state_t state;
        logic latched;
        logic latch_is_trap;
        logic [4:0] latch_vec;
        elpc_cpu_ctl_t cpu;
        elpc_clk_ctl_t clk;
        logic core_reset;
        logic break_state;
        logic flag_clear_allow;
        logic stab_hold_clear;
        logic break_flag_clear_enable;
        logic wake_flag;
        logic short_rec;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic readyout;
    } elpc_regs_t;

    elpc_regs_t cur;
    elpc_regs_t next_cur;
    logic recov_done;
    logic [ELPC_NUM_IRQ-1:0] live_irq;
    logic [5:0] picked;
    logic [7:0] flags_low;
    logic [7:0] flags_mid;
    logic [7:0] flags_high;
    logic addr_phase;
    logic boundary;

    elpc_recovery_counter u_recovery (
        .hclk(hclk),
        .hresetn(hresetn),
        .hold_clear(cur.stab_hold_clear),
        .short_sel(cur.short_rec),
        .done(recov_done)
    );

    // ==========================================================
    // Live flags and decode
    always_comb begin
        live_irq = irq_req & irq_enable;
        picked = pick_source(live_irq);
        flags_low = {irq_req[5:0], 2'b00};
        flags_mid = irq_req[13:6];
        flags_high = {2'b00, irq_req[19:14]};
        addr_phase = hsel && hready && (htrans == ELPC_HTRANS_NONSEQ);
        boundary = instr_done || rti_done;
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_cur = cur;
        next_cur.cpu.int_start = 1'b0;
        next_cur.cpu.stack_push = 1'b0;
        next_cur.cpu.set_imask = 1'b0;
        next_cur.cpu.clear_imask = 1'b0;
        next_cur.cpu.discard_prefetch = 1'b0;
        next_cur.cpu.stack_high_index = 1'b0;
        next_cur.core_reset = 1'b0;

        // Bus data phase: writes land, read data prepared one cycle early
        next_cur.readyout = 1'b1;
        if (cur.dp_write) begin
            if (cur.dp_addr == ELPC_OFS_BRK_CTRL) begin
                next_cur.break_flag_clear_enable = hwdata[ELPC_BREAK_FLAG_CLEAR_ENABLE_BIT];
            end else if (cur.dp_addr == ELPC_OFS_BRK_STAT) begin
                next_cur.wake_flag = cur.wake_flag & hwdata[ELPC_WAKE_BIT];
            end else if (cur.dp_addr == ELPC_OFS_OPTION) begin
                next_cur.short_rec = hwdata[ELPC_SHORT_RECOVERY_SELECT_BIT];
            end
        end
        next_cur.dp_write = 1'b0;
        if (addr_phase) begin
            next_cur.dp_write = hwrite && (hsize == ELPC_HSIZE_WORD);
            next_cur.dp_addr = haddr;
            next_cur.rdata = '0;
            if (!hwrite) begin
                if (haddr == ELPC_OFS_FLAGS_LOW) begin
                    next_cur.rdata = {24'h00_0000, flags_low};
                end else if (haddr == ELPC_OFS_FLAGS_MID) begin
                    next_cur.rdata = {24'h00_0000, flags_mid};
                end else if (haddr == ELPC_OFS_FLAGS_HIGH) begin
                    next_cur.rdata = {24'h00_0000, flags_high};
                end else if (haddr == ELPC_OFS_BRK_CTRL) begin
                    next_cur.rdata = 32'(cur.break_flag_clear_enable);
                end else if (haddr == ELPC_OFS_BRK_STAT) begin
                    next_cur.rdata = 32'(cur.wake_flag);
                end else if (haddr == ELPC_OFS_OPTION) begin
                    next_cur.rdata = 32'(cur.short_rec);
                end
            end
        end

        // Exception and low-power sequencer
        case (cur.state)
            ELPC_RUN: begin
                next_cur.clk = '{1'b1, 1'b1, 1'b1, 1'b1};
                if (boundary) begin
                    next_cur.cpu.discard_prefetch = rti_done && (trap_exec || break_req
                        || (picked[5] && !cpu_imask));
                    if (trap_exec) begin
                        next_cur.latched = 1'b1;
                        next_cur.latch_is_trap = 1'b1;
                        next_cur.latch_vec = ELPC_VEC_SWI;
                        next_cur.state = ELPC_ENTRY;
                    end else if (break_req) begin
                        next_cur.latched = 1'b1;
                        next_cur.latch_is_trap = 1'b1;
                        next_cur.latch_vec = ELPC_VEC_SWI;
                        next_cur.break_state = 1'b1;
                        next_cur.state = ELPC_ENTRY;
                    end else if (picked[5] && !cpu_imask) begin
                        next_cur.latched = 1'b1;
                        next_cur.latch_is_trap = 1'b0;
                        next_cur.latch_vec = ELPC_VEC_IRQ_BASE + picked[4:0];
                        next_cur.state = ELPC_ENTRY;
                    end else if (wait_exec) begin
                        next_cur.cpu.clear_imask = 1'b1;
                        next_cur.clk.core_clk_en = 1'b0;
                        next_cur.state = ELPC_WAIT;
                    end else if (stop_exec) begin
                        next_cur.cpu.clear_imask = 1'b1;
                        next_cur.clk = '{1'b0, 1'b0, 1'b0, 1'b0};
                        next_cur.stab_hold_clear = 1'b1;
                        next_cur.state = ELPC_STOP;
                    end
                end
            end
            ELPC_ENTRY: begin
                next_cur.clk.core_clk_en = 1'b1;
                next_cur.cpu.int_start = 1'b1;
                next_cur.cpu.stack_push = 1'b1;
                next_cur.cpu.set_imask = 1'b1;
                next_cur.cpu.pc_minus_one = !cur.latch_is_trap;
                next_cur.cpu.vector_sel = cur.latch_vec;
                next_cur.state = ELPC_SERVICE;
            end
            ELPC_SERVICE: begin
                if (vector_ack || (!cpu_imask && !cur.cpu.set_imask)) begin
                    next_cur.latched = 1'b0;
                    next_cur.state = ELPC_RUN;
                end
            end
            ELPC_WAIT: begin
                if (break_req && emu_mode) begin
                    next_cur.wake_flag = 1'b1;
                    next_cur.break_state = 1'b1;
                    next_cur.latched = 1'b1;
                    next_cur.latch_is_trap = 1'b1;
                    next_cur.latch_vec = ELPC_VEC_SWI;
                    next_cur.state = ELPC_ENTRY;
                end else if (picked[5]) begin
                    next_cur.latched = 1'b1;
                    next_cur.latch_is_trap = 1'b0;
                    next_cur.latch_vec = ELPC_VEC_IRQ_BASE + picked[4:0];
                    next_cur.state = ELPC_ENTRY;
                end
            end
            ELPC_STOP: begin
                if (picked[5] || (break_req && emu_mode)) begin
                    next_cur.stab_hold_clear = 1'b0;
                    next_cur.clk.xtal_clk_en = 1'b1;
                    next_cur.clk.main_clk_en = 1'b1;
                    next_cur.state = ELPC_RECOVER;
                end
            end
            ELPC_RECOVER: begin
                if (recov_done) begin
                    next_cur.clk = '{1'b1, 1'b1, 1'b1, 1'b1};
                    next_cur.latched = 1'b1;
                    if (break_req && emu_mode) begin
                        next_cur.wake_flag = 1'b1;
                        next_cur.break_state = 1'b1;
                        next_cur.latch_is_trap = 1'b1;
                        next_cur.latch_vec = ELPC_VEC_SWI;
                    end else begin
                        next_cur.latch_is_trap = 1'b0;
                        next_cur.latch_vec = ELPC_VEC_IRQ_BASE + picked[4:0];
                    end
                    next_cur.state = ELPC_ENTRY;
                end
            end
            default: begin
                next_cur.state = ELPC_RUN;
            end
        endcase

        if (break_exit && cur.state != ELPC_ENTRY) begin
            next_cur.break_state = 1'b0;
        end
        next_cur.flag_clear_allow = !next_cur.break_state || next_cur.break_flag_clear_enable;

        if (reset_req) begin
            next_cur.core_reset = 1'b1;
            next_cur.state = ELPC_RUN;
            next_cur.latched = 1'b0;
            next_cur.break_state = 1'b0;
            next_cur.flag_clear_allow = 1'b1;
            next_cur.stab_hold_clear = 1'b0;
            next_cur.cpu.int_start = 1'b0;
            next_cur.cpu.stack_push = 1'b0;
            next_cur.cpu.set_imask = 1'b0;
            next_cur.cpu.clear_imask = 1'b0;
            next_cur.cpu.vector_sel = ELPC_VEC_RESET;
            next_cur.clk = '{1'b1, 1'b1, 1'b1, 1'b1};
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur <= '{state: ELPC_RUN, latched: 1'b0, latch_is_trap: 1'b0,
                latch_vec: ELPC_VEC_RESET, cpu: '0, clk: '{1'b1, 1'b1, 1'b1, 1'b1},
                core_reset: 1'b0, break_state: 1'b0, flag_clear_allow: 1'b1,
                stab_hold_clear: 1'b0, break_flag_clear_enable: ELPC_BREAK_FLAG_CLEAR_ENABLE_RST, wake_flag: 1'b0,
                short_rec: ELPC_SHORT_RECOVERY_SELECT_RST, dp_write: 1'b0, dp_addr: 8'h00,
                rdata: ELPC_RDATA_RST, readyout: 1'b1};
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // Outputs
    assign hreadyout = cur.readyout;
    assign hrdata = cur.rdata;
    assign hresp = 1'b0;
    assign core_reset = cur.core_reset;
    assign int_start = cur.cpu.int_start;
    assign stack_push = cur.cpu.stack_push;
    assign set_imask = cur.cpu.set_imask;
    assign clear_imask = cur.cpu.clear_imask;
    assign pc_minus_one = cur.cpu.pc_minus_one;
    assign stack_high_index = cur.cpu.stack_high_index;
    assign discard_prefetch = cur.cpu.discard_prefetch;
    assign vector_sel = cur.cpu.vector_sel;
    assign core_clk_en = cur.clk.core_clk_en;
    assign periph_clk_en = cur.clk.periph_clk_en;
    assign main_clk_en = cur.clk.main_clk_en;
    assign xtal_clk_en = cur.clk.xtal_clk_en;
    assign break_state = cur.break_state;
    assign flag_clear_allow = cur.flag_clear_allow;
    assign stab_hold_clear = cur.stab_hold_clear;

endmodule : elpc_top

`default_nettype wire

// ---- sim/elpc_top_chk.sv ----
// Port checker of the exception and low-power controller.
// Sees only elpc_top ports; bound to it from the testbench top file.
`timescale 1ns/1ps
`default_nettype none

module elpc_top_chk
    import elpc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [ELPC_NUM_IRQ-1:0] irq_req,
    input wire logic [ELPC_NUM_IRQ-1:0] irq_enable,
    input wire logic reset_req,
    input wire logic core_reset,
    input wire logic int_start,
    input wire logic stack_push,
    input wire logic set_imask,
    input wire logic clear_imask,
    input wire logic pc_minus_one,
    input wire logic stack_high_index,
    input wire logic [4:0] vector_sel,
    input wire logic core_clk_en,
    input wire logic periph_clk_en,
    input wire logic main_clk_en,
    input wire logic break_state,
    input wire logic flag_clear_allow,
    input wire logic stab_hold_clear
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ========
    // Assertions
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    chk_entry_push: assert property (int_start |-> stack_push && set_imask ##1 !int_start)
        else $error("entry without push and mask");
    chk_no_high_index: assert property (!stack_high_index)
        else $error("high index stacked");
    chk_trap_pc: assert property (int_start && !pc_minus_one |->
        vector_sel == ELPC_VEC_SWI)
        else $error("trap stacking on a hardware vector");
    chk_hw_enabled: assert property (int_start && pc_minus_one |->
        vector_sel >= ELPC_VEC_IRQ_BASE && irq_enable[vector_sel - ELPC_VEC_IRQ_BASE])
        else $error("hardware entry for a disabled source");
    chk_reset_first: assert property (reset_req |=>
        core_reset && vector_sel == ELPC_VEC_RESET)
        else $error("reset not taken first");
    chk_sleep_mask: assert property ($fell(core_clk_en) |-> clear_imask)
        else $error("core halted without mask clear");
    chk_wait_wake: assert property (!core_clk_en && periph_clk_en
        && $rose(|(irq_req & irq_enable)) && !reset_req |-> ##2 int_start)
        else $error("wait wake-up stacking late");
    chk_stop_gate: assert property (stab_hold_clear |-> !main_clk_en && !periph_clk_en)
        else $error("clocks running while counter held");
    chk_break_guard: assert property (!break_state |-> flag_clear_allow)
        else $error("flags protected outside break");
endmodule : elpc_top_chk

`default_nettype wire

// ---- sim/elpc_core_model.sv ----
// Behavioural model of the core beside the controller: boundary pulses, mask, vector fetch.
// Assumes the testbench asks for one instruction kind per op_valid pulse.
`timescale 1ns/1ps
`default_nettype none

module elpc_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic op_valid,
    input wire logic [2:0] op_kind,
    input wire logic ack_slow,
    input wire logic set_imask,
    input wire logic clear_imask,
    input wire logic int_start,
    output logic instr_done,
    output logic rti_done,
    output logic trap_exec,
    output logic wait_exec,
    output logic stop_exec,
    output logic vector_ack,
    output logic cpu_imask
);
    logic [3:0] ack_sr;

    // ========
    // Boundary pulses, vector fetch and mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {instr_done, rti_done, trap_exec, wait_exec, stop_exec, vector_ack} <= '0;
            ack_sr <= '0;
            cpu_imask <= 1'b1;
        end else begin
            instr_done <= op_valid && op_kind != 3'h4;
            rti_done <= op_valid && op_kind == 3'h4;
            trap_exec <= op_valid && op_kind == 3'h1;
            wait_exec <= op_valid && op_kind == 3'h2;
            stop_exec <= op_valid && op_kind == 3'h3;
            ack_sr <= {ack_sr[2:0], int_start};
            vector_ack <= ack_slow ? ack_sr[3] : ack_sr[0];
            if (set_imask) begin
                cpu_imask <= 1'b1;
            end else if (clear_imask || (op_valid && op_kind == 3'h4)) begin
                cpu_imask <= 1'b0;
            end
        end
    end
endmodule : elpc_core_model

`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking testbench of the exception and low-power controller.
// Assumes a 25 MHz hclk; core model beside the design, checker bound to it.
`timescale 1ns/1ps
`default_nettype none

module tb
    import elpc_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hready = 1;
    logic [7:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = ELPC_HSIZE_WORD;
    logic [31:0] hwdata = '0, hrdata, d;
    logic [ELPC_NUM_IRQ-1:0] irq_req = '0, irq_enable = '0, pend;
    logic [2:0] op_kind = '0;
    logic op_valid = 0, ack_slow = 0, reset_req = 0, break_req = 0, break_exit = 0, emu_mode = 0;
    logic hreadyout, hresp, cpu_imask, instr_done, rti_done, trap_exec, wait_exec, stop_exec;
    logic vector_ack, core_reset, int_start, stack_push, set_imask, clear_imask, pc_minus_one;
    logic stack_high_index, discard_prefetch, core_clk_en, periph_clk_en, main_clk_en;
    logic xtal_clk_en, break_state, flag_clear_allow, stab_hold_clear, pf;
    logic [4:0] vector_sel;
    integer seed = 32'hc05b, n_errors = 0, compares = 0, i, k, n, m;

    always #20 hclk = ~hclk;
    elpc_top elpc_top_inst (.*);
    elpc_core_model elpc_core_model_inst (.*);

    // ========
    // Tasks
    task automatic end_sim;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= ELPC_HTRANS_NONSEQ;
        for (n = 0; n < 2; n++) begin
            k = 0;
            do begin
                @(posedge hclk);
                k++;
            end while (hreadyout !== 1'b1 && k < 100);
            if (k >= 100) begin
                n_errors++;
                end_sim();
            end
            htrans <= 2'h0;
            hwdata <= wd;
        end
        d = hrdata;
    endtask : ahb

    task automatic op(input int kind);
        @(posedge hclk);
        op_valid <= 1;
        op_kind <= 3'(kind);
        @(posedge hclk);
        op_valid <= 0;
    endtask : op

    task automatic entry(input logic [4:0] v, input logic pc);
        k = 0;
        pf = 1'b0;
        do begin
            @(negedge hclk);
            k++;
            pf |= discard_prefetch;
        end while (int_start !== 1'b1 && k < 5000);
        if (k >= 5000) begin
            n_errors++;
            end_sim();
        end
        cmp(vector_sel, v);
        cmp(pc_minus_one, pc);
        cmp(pf, op_kind == 3'h4);
        @(posedge hclk);
    endtask : entry

    task automatic quiet;
        repeat (6) begin
            @(negedge hclk);
            cmp(int_start, 1'b0);
        end
        @(posedge hclk);
    endtask : quiet

    task automatic ret;
        repeat (6) @(posedge hclk);
        op(4);
    endtask : ret

    function automatic logic [4:0] vec_of(input logic [ELPC_NUM_IRQ-1:0] p);
        for (int j = 0; j < ELPC_NUM_IRQ; j++) begin
            if (p[j]) return ELPC_VEC_IRQ_BASE + 5'(j);
        end
        return ELPC_VEC_RESET;
    endfunction : vec_of

    // ========
    // Scenarios
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        for (i = 12; i < 28; i += 4) begin
            ahb(8'(i), 0, 0);
            cmp(d, ELPC_RDATA_RST);
        end
        for (i = 0; i < 4; i++) begin
            irq_req <= 20'($random(seed));
            ahb(ELPC_OFS_FLAGS_LOW + 8'(4 * (i % 3)), 1, '1);
            ahb(ELPC_OFS_FLAGS_LOW, 0, 0);
            cmp(d, {24'h0, irq_req[5:0], 2'b00});
            ahb(ELPC_OFS_FLAGS_MID, 0, 0);
            cmp(d, {24'h0, irq_req[13:6]});
            ahb(ELPC_OFS_FLAGS_HIGH, 0, 0);
            cmp(d, {26'h0, irq_req[19:14]});
        end
        irq_enable <= '1;
        irq_req <= 20'h0_0004;
        op(0);
        quiet();
        op(1);
        entry(ELPC_VEC_SWI, 1'b0);
        irq_req <= '0;
        ret();
        irq_req <= 20'h0_0008;
        irq_enable <= '0;
        op(0);
        quiet();
        for (i = 0; i < 3; i++) begin
            ack_slow <= i[0];
            irq_enable <= 20'($random(seed)) | 20'h0_8000;
            irq_req <= 20'($random(seed)) | 20'h0_8000;
            op(0);
            pend = irq_req & irq_enable;
            while (pend != 0) begin
                entry(vec_of(pend), 1'b1);
                pend = pend & (pend - 1);
                irq_req <= (irq_req & ~irq_enable) | pend;
                ret();
            end
            quiet();
        end
        irq_req <= '0;
        irq_enable <= '1;
        op(2);
        quiet();
        cmp({core_clk_en, periph_clk_en}, 2'b01);
        irq_req <= 20'h0_0010;
        entry(ELPC_VEC_IRQ_BASE + 5'h4, 1'b1);
        irq_req <= '0;
        ret();
        for (i = 1; i >= 0; i--) begin
            ahb(ELPC_OFS_OPTION, 1, 32'(i));
            op(3);
            quiet();
            cmp({xtal_clk_en, main_clk_en, core_clk_en, stab_hold_clear}, 4'h1);
            irq_req <= 20'h0_0001;
            m = 0;
            k = 0;
            while (core_clk_en !== 1'b1 && k < 5000) begin
                @(negedge hclk);
                k++;
                m += 32'(main_clk_en === 1'b1);
            end
            if (k >= 5000) begin
                n_errors++;
                end_sim();
            end
            cmp(m >= (i ? 32 : 4096) && m <= (i ? 36 : 4100), 1'b1);
            entry(ELPC_VEC_IRQ_BASE, 1'b1);
            irq_req <= '0;
            ret();
        end
        ahb(ELPC_OFS_BRK_CTRL, 1, 0);
        break_req <= 1;
        op(0);
        entry(ELPC_VEC_SWI, 1'b0);
        break_req <= 0;
        cmp({break_state, flag_clear_allow}, 2'b10);
        ahb(ELPC_OFS_BRK_CTRL, 1, 1);
        @(negedge hclk);
        cmp({break_state, flag_clear_allow}, 2'b11);
        ahb(ELPC_OFS_BRK_CTRL, 0, 0);
        cmp(d, 1);
        ahb(ELPC_OFS_BRK_CTRL, 1, 0);
        break_exit <= 1;
        @(posedge hclk);
        break_exit <= 0;
        @(negedge hclk);
        cmp({break_state, flag_clear_allow}, 2'b01);
        ret();
        emu_mode <= 1;
        op(2);
        quiet();
        break_req <= 1;
        entry(ELPC_VEC_SWI, 1'b0);
        break_req <= 0;
        ahb(ELPC_OFS_BRK_STAT, 0, 0);
        cmp(d, 1);
        ahb(ELPC_OFS_BRK_STAT, 1, 0);
        ahb(ELPC_OFS_BRK_STAT, 0, 0);
        cmp(d, 0);
        reset_req <= 1;
        @(posedge hclk);
        reset_req <= 0;
        @(negedge hclk);
        cmp({core_reset, break_state, vector_sel}, 7'h40);
        end_sim();
    end
endmodule : tb

bind elpc_top elpc_top_chk elpc_top_chk_inst (.*);

`default_nettype wire
